/* verilog/alu_dsp_defines.svh */
`ifndef ALU_DSP_DEFINES_SVH
`define ALU_DSP_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FIRST_ACCUMULATOR_L 8'h08
`define OFS_FIRST_ACCUMULATOR_H 8'h0c
`define OFS_FIRST_ACCUMULATOR_U 8'h10
`define OFS_SECOND_ACCUMULATOR_L 8'h14
`define OFS_SECOND_ACCUMULATOR_H 8'h18
`define OFS_SECOND_ACCUMULATOR_U 8'h1c

// ----------------------------------------------------------------
// Control word fields and reset values
// ----------------------------------------------------------------
`define CTL_FRAC 0
`define CTL_RND 1
`define CTL_CLAMP_MODE 2
`define CTL_MEM_CLAMP 3
`define CTL_B_CLAMP 4
`define CTL_A_CLAMP 5
`define CTL_UNSIGNED 6
`define CTL_W 7
`define CTL_RESET 7'h09
`define STATUS_RESET 5'h00

// ----------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------
`define DIV_CYCLES 5'h10
`define SAT_MAX40 40'h7fffffffff
`define SAT_MIN40 40'h8000000000
`define SAT_MAX32 40'h007fffffff
`define SAT_MIN32 40'hff80000000
`define RND_HALF 16'h8000
`define SAT_MAX16 16'h7fff
`define SAT_MIN16 16'h8000
`define LIT_MASK 16'h001f
`define BYTE_MASK 16'h00ff

`endif

/* verilog/alu_dsp_pkg.sv */
package alu_dsp_pkg;

   typedef enum logic [4:0] {
      OP_ADD = 5'b00000, OP_SUB = 5'b00001, OP_AND = 5'b00010, OP_OR = 5'b00011,
      OP_XOR = 5'b00100, OP_SHL = 5'b00101, OP_SHR = 5'b00110, OP_ASR = 5'b00111,
      OP_MUL_SS = 5'b01000, OP_MUL_UU = 5'b01001, OP_MUL_SU = 5'b01010,
      OP_MUL_US = 5'b01011, OP_MUL_B = 5'b01100,
      OP_DIV_S32 = 5'b01101, OP_DIV_U32 = 5'b01110, OP_DIV_S16 = 5'b01111,
      OP_DIV_U16 = 5'b10000,
      OP_ACC_ZERO = 5'b10001, OP_SQ_DIFF = 5'b10010, OP_SQ_DIFF_ACC = 5'b10011,
      OP_MAC = 5'b10100, OP_PROD_LOAD = 5'b10101, OP_NEG_PROD_LOAD = 5'b10110,
      OP_MULT_SUB = 5'b10111, OP_PREFETCH_WB = 5'b11000,
      OP_ACC_ADD = 5'b11001, OP_ACC_SUB = 5'b11010, OP_ACC_NEG = 5'b11011
   } op_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_DIV = 1'b1
   } div_state_e;

   typedef struct packed {
      op_e code;
      logic byte_mode;
      logic dest_mem;
      logic lit5;
      logic acc_sel;
      logic wb;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] x_hi;
   } op_s;

   typedef struct packed {
      logic dc;
      logic n;
      logic ov;
      logic z;
      logic c;
   } flags_s;

   typedef struct packed {
      logic valid;
      logic dest_mem;
      logic [15:0] lo;
      logic [15:0] hi;
   } result_s;

endpackage : alu_dsp_pkg

/* verilog/cpu_alu_dsp_datapath.sv */
// What this block does
// - 16-bit ALU doing add, subtract, shifts and bitwise logic.
// - Arithmetic treats operands as two's complement unless defined otherwise.
// - Operations update carry, zero, negative, signed wrap and half carry in status.
// - On subtract, carry is the borrow indicator and half carry the digit borrow.
// - Each ALU operation runs at byte or word width chosen by the instruction.
// - Operands from registers or memory; result may go to either destination.
// - MCU multiplies run on the shared 17x17 signed/unsigned/mixed multiplier.
// - 16x16 all sign mixes, 16 times 5-bit literal, and 8x8 unsigned.
// - Divide 32/16 and 16/16, each signed and unsigned.
// - Quotient goes to quotient register, remainder to remainder register.
// - Divisor any register; 32-bit dividend from aligned pair, high register upper half.
// - Division takes one cycle per divisor bit, same for both dividend sizes.
// - DSP has 17x17 multiplier, shifter, 40-bit adder, two accumulators, round, clamp.
// - DSP work never overlaps other instructions; no instruction uses both the ALU and the DSP.
// - Accumulator add, subtract and negate need no operand beyond accumulators.
// - Control bits pick fractional/integer and signed/unsigned DSP multiply.
// - Round mode bit picks conventional or convergent rounding.
// - Separate clamp enables for each accumulator and memory writes, plus clamp mode.
// - DSP ops: zero, squared difference, accumulate, load, negated load, subtract, keep.
//
// Design decisions made here: the register offsets and the APB register port.
`include "alu_dsp_defines.svh"

module cpu_alu_dsp_datapath (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   input wire logic op_valid,
   input wire alu_dsp_pkg::op_s op,
   output alu_dsp_pkg::result_s res_q,
   output alu_dsp_pkg::flags_s status_q,
   output logic div_done_q,
   output logic busy_q
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [39:0] sat40(input logic [40:0] v, input logic en,
                                         input logic mode);
      logic [39:0] r;
      r = v[39:0];
      if (en && mode && (v[40] != v[39])) begin
         r = v[40] ? `SAT_MIN40 : `SAT_MAX40;
      end else if (en && !mode && !(&v[40:31]) && (|v[40:31])) begin
         r = v[40] ? `SAT_MIN32 : `SAT_MAX32;
      end
      return r;
   endfunction : sat40

   function automatic logic [31:0] cond_neg(input logic [31:0] v, input logic neg);
      return neg ? 32'(-v) : v;
   endfunction : cond_neg

   function automatic logic [40:0] ext41(input logic [39:0] v);
      return {v[39], v};
   endfunction : ext41

   // Rounds bits 31:16 of an accumulator, optionally clamped to 16 bits
   function automatic logic [15:0] round16(input logic [39:0] a, input logic conv,
                                           input logic sat);
      logic [40:0] s;
      logic [15:0] r;
      logic tie_even;
      tie_even = conv && (a[15:0] == `RND_HALF) && !a[16];
      s = ext41(a) + {25'h0, (tie_even ? 16'h0 : `RND_HALF)};
      r = s[31:16];
      if (sat && !(&s[40:31]) && (|s[40:31])) begin
         r = s[40] ? `SAT_MIN16 : `SAT_MAX16;
      end
      return r;
   endfunction : round16

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [`CTL_W-1:0] ctrl_q;
   logic [39:0] acc_a_q, acc_b_q;
   alu_dsp_pkg::div_state_e div_st_q;
   logic [4:0] div_cnt_q;
   logic [16:0] div_rem_q;
   logic [15:0] div_lo_q, div_den_q;
   logic div_qneg_q, div_rneg_q, div_ovf_q, div_dest_q;

   wire frac_sel = ctrl_q[`CTL_FRAC];
   wire rnd_conv = ctrl_q[`CTL_RND];
   wire clamp_mode = ctrl_q[`CTL_CLAMP_MODE];
   wire mem_clamp = ctrl_q[`CTL_MEM_CLAMP];
   wire uns_sel = ctrl_q[`CTL_UNSIGNED];

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   wire hit_ctrl = paddr == `OFS_CTRL;
   wire hit_stat = paddr == `OFS_STATUS;
   wire hit_aal = paddr == `OFS_FIRST_ACCUMULATOR_L;
   wire hit_aah = paddr == `OFS_FIRST_ACCUMULATOR_H;
   wire hit_aau = paddr == `OFS_FIRST_ACCUMULATOR_U;
   wire hit_abl = paddr == `OFS_SECOND_ACCUMULATOR_L;
   wire hit_abh = paddr == `OFS_SECOND_ACCUMULATOR_H;
   wire hit_abu = paddr == `OFS_SECOND_ACCUMULATOR_U;
   wire hit_any = hit_ctrl | hit_stat | hit_aal | hit_aah | hit_aau | hit_abl | hit_abh
                  | hit_abu;
   wire apb_access = psel & penable;
   wire apb_done = apb_access & pready_q;
   wire apb_wr = apb_done & pwrite & hit_any;
   wire [31:0] rd_data =
      hit_ctrl ? {25'h0, ctrl_q} :
      hit_stat ? {27'h0, status_q} :
      hit_aal ? {16'h0, acc_a_q[15:0]} :
      hit_aah ? {16'h0, acc_a_q[31:16]} :
      hit_aau ? {16'h0, {8{acc_a_q[39]}}, acc_a_q[39:32]} :
      hit_abl ? {16'h0, acc_b_q[15:0]} :
      hit_abh ? {16'h0, acc_b_q[31:16]} :
      hit_abu ? {16'h0, {8{acc_b_q[39]}}, acc_b_q[39:32]} : 32'h0;

   // ---------------------------------------------------------------
   // Issue and op classes
   // ---------------------------------------------------------------
   wire issue = op_valid && (div_st_q == alu_dsp_pkg::ST_IDLE);
   wire is_sub = op.code == alu_dsp_pkg::OP_SUB;
   wire is_arith = (op.code == alu_dsp_pkg::OP_ADD) || is_sub;
   wire is_logic = (op.code == alu_dsp_pkg::OP_AND) || (op.code == alu_dsp_pkg::OP_OR)
                   || (op.code == alu_dsp_pkg::OP_XOR);
   wire is_shift = (op.code == alu_dsp_pkg::OP_SHL) || (op.code == alu_dsp_pkg::OP_SHR)
                   || (op.code == alu_dsp_pkg::OP_ASR);
   wire is_mul = (op.code >= alu_dsp_pkg::OP_MUL_SS) && (op.code <= alu_dsp_pkg::OP_MUL_B);
   wire is_div = (op.code >= alu_dsp_pkg::OP_DIV_S32) && (op.code <= alu_dsp_pkg::OP_DIV_U16);
   wire is_dsp = op.code >= alu_dsp_pkg::OP_ACC_ZERO;
   wire is_sq = (op.code == alu_dsp_pkg::OP_SQ_DIFF)
                || (op.code == alu_dsp_pkg::OP_SQ_DIFF_ACC);
   wire can_wb = (op.code == alu_dsp_pkg::OP_ACC_ZERO) || (op.code == alu_dsp_pkg::OP_MAC)
                 || (op.code == alu_dsp_pkg::OP_PREFETCH_WB)
                 || (op.code == alu_dsp_pkg::OP_MULT_SUB);

   // ---------------------------------------------------------------
   // Integer ALU
   // ---------------------------------------------------------------
   wire [15:0] b_eff = is_sub ? ~op.y : op.y;
   wire cin = is_sub;
   wire [16:0] sum17 = {1'b0, op.x} + {1'b0, b_eff} + {16'h0, cin};
   wire [8:0] sum9 = {1'b0, op.x[7:0]} + {1'b0, b_eff[7:0]} + {8'h0, cin};
   wire [4:0] sum5 = {1'b0, op.x[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
   wire [15:0] sh_in = op.byte_mode ?
      {((op.code == alu_dsp_pkg::OP_ASR) && op.x[7]) ? 8'hff : 8'h00, op.x[7:0]} : op.x;
   wire [16:0] shl17 = 17'({1'b0, sh_in} << op.y[3:0]);
   wire [17:0] shr_src = {(op.code == alu_dsp_pkg::OP_ASR) & sh_in[15], sh_in, 1'b0};
   wire [17:0] shr18 = 18'($signed(shr_src) >>> op.y[3:0]);

   logic [15:0] alu_r, alu_out;
   logic alu_c, alu_ov;
   always_comb begin
      alu_c = 1'b0;
      alu_ov = 1'b0;
      case (op.code)
         alu_dsp_pkg::OP_ADD, alu_dsp_pkg::OP_SUB: begin
            alu_r = sum17[15:0];
            alu_c = op.byte_mode ? sum9[8] : sum17[16];
            alu_ov = op.byte_mode ?
               (op.x[7] == b_eff[7]) && (sum9[7] != op.x[7]) :
               (op.x[15] == b_eff[15]) && (sum17[15] != op.x[15]);
         end
         alu_dsp_pkg::OP_AND: alu_r = op.x & op.y;
         alu_dsp_pkg::OP_OR: alu_r = op.x | op.y;
         alu_dsp_pkg::OP_XOR: alu_r = op.x ^ op.y;
         alu_dsp_pkg::OP_SHL: begin
            alu_r = shl17[15:0];
            alu_c = op.byte_mode ? shl17[8] : shl17[16];
         end
         alu_dsp_pkg::OP_SHR, alu_dsp_pkg::OP_ASR: begin
            alu_r = shr18[16:1];
            alu_c = shr18[0];
         end
         default: alu_r = 16'h0;
      endcase
      // Byte ops leave the upper byte of the first operand untouched
      alu_out = op.byte_mode ? {op.x[15:8], alu_r[7:0]} : alu_r;
   end

   wire alu_z = op.byte_mode ? (alu_r[7:0] == 8'h00) : (alu_r == 16'h0);
   wire alu_n = op.byte_mode ? alu_r[7] : alu_r[15];
   wire alu_dc = sum5[4];

   // ---------------------------------------------------------------
   // Shared 17x17 multiplier
   // ---------------------------------------------------------------
   wire [16:0] sq_diff = 17'({op.x[15], op.x} - {op.y[15], op.y});
   logic [16:0] mx, my;
   logic [15:0] my_raw;
   always_comb begin
      my_raw = op.lit5 ? (op.y & `LIT_MASK) : op.y;
      case (op.code)
         alu_dsp_pkg::OP_MUL_SS: begin
            mx = {op.x[15], op.x};
            my = {my_raw[15], my_raw};
         end
         alu_dsp_pkg::OP_MUL_SU: begin
            mx = {op.x[15], op.x};
            my = {1'b0, my_raw};
         end
         alu_dsp_pkg::OP_MUL_US: begin
            mx = {1'b0, op.x};
            my = {my_raw[15], my_raw};
         end
         alu_dsp_pkg::OP_MUL_B: begin
            mx = {1'b0, op.x & `BYTE_MASK};
            my = {1'b0, op.y & `BYTE_MASK};
         end
         alu_dsp_pkg::OP_SQ_DIFF, alu_dsp_pkg::OP_SQ_DIFF_ACC: begin
            mx = sq_diff;
            my = sq_diff;
         end
         default: begin
            if (is_dsp && !uns_sel) begin
               mx = {op.x[15], op.x};
               my = {op.y[15], op.y};
            end else begin
               mx = {1'b0, op.x};
               my = {1'b0, my_raw};
            end
         end
      endcase
   end
   wire [33:0] prod = 34'($signed(mx) * $signed(my));
   wire [39:0] prod_ext = {{6{prod[33]}}, prod};
   wire [39:0] prod40 = frac_sel ? {prod_ext[38:0], 1'b0} : prod_ext;

   // ---------------------------------------------------------------
   // DSP 40-bit adder and accumulator update
   // ---------------------------------------------------------------
   wire [39:0] acc_cur = op.acc_sel ? acc_b_q : acc_a_q;
   wire [39:0] acc_oth = op.acc_sel ? acc_a_q : acc_b_q;
   logic [40:0] d_lhs, d_rhs;
   logic d_sub;
   always_comb begin
      d_lhs = 41'h0;
      d_rhs = 41'h0;
      d_sub = 1'b0;
      case (op.code)
         alu_dsp_pkg::OP_SQ_DIFF, alu_dsp_pkg::OP_PROD_LOAD: d_rhs = ext41(prod40);
         alu_dsp_pkg::OP_SQ_DIFF_ACC, alu_dsp_pkg::OP_MAC: begin
            d_lhs = ext41(acc_cur);
            d_rhs = ext41(prod40);
         end
         alu_dsp_pkg::OP_NEG_PROD_LOAD: begin
            d_rhs = ext41(prod40);
            d_sub = 1'b1;
         end
         alu_dsp_pkg::OP_MULT_SUB: begin
            d_lhs = ext41(acc_cur);
            d_rhs = ext41(prod40);
            d_sub = 1'b1;
         end
         alu_dsp_pkg::OP_PREFETCH_WB: d_lhs = ext41(acc_cur);
         alu_dsp_pkg::OP_ACC_ADD: begin
            d_lhs = ext41(acc_cur);
            d_rhs = ext41(acc_oth);
         end
         alu_dsp_pkg::OP_ACC_SUB: begin
            d_lhs = ext41(acc_cur);
            d_rhs = ext41(acc_oth);
            d_sub = 1'b1;
         end
         alu_dsp_pkg::OP_ACC_NEG: begin
            d_rhs = ext41(acc_cur);
            d_sub = 1'b1;
         end
         default: d_lhs = 41'h0;
      endcase
   end
   wire [40:0] d_sum = d_sub ? 41'(d_lhs - d_rhs) : 41'(d_lhs + d_rhs);
   wire clamp_en = op.acc_sel ? ctrl_q[`CTL_B_CLAMP] : ctrl_q[`CTL_A_CLAMP];
   wire [39:0] acc_new = sat40(d_sum, clamp_en, clamp_mode);
   wire [15:0] wb_word = round16(acc_oth, rnd_conv, mem_clamp);

   // ---------------------------------------------------------------
   // Divider setup and iteration
   // ---------------------------------------------------------------
   wire div_signed = (op.code == alu_dsp_pkg::OP_DIV_S32)
                     || (op.code == alu_dsp_pkg::OP_DIV_S16);
   wire div_long = (op.code == alu_dsp_pkg::OP_DIV_S32)
                   || (op.code == alu_dsp_pkg::OP_DIV_U32);
   // Upper half of a long dividend comes from the higher register of the pair
   wire [31:0] dvd_raw = div_long ? {op.x_hi, op.x}
                         : {div_signed ? {16{op.x[15]}} : 16'h0, op.x};
   wire dvd_neg = div_signed & dvd_raw[31];
   wire den_neg = div_signed & op.y[15];
   wire [31:0] dvd_mag = cond_neg(dvd_raw, dvd_neg);
   wire [31:0] den_mag32 = cond_neg({16'h0, op.y}, den_neg);
   wire [15:0] den_mag = den_mag32[15:0];
   wire div_ovf = (den_mag == 16'h0) || (dvd_mag[31:16] >= den_mag);

   wire [16:0] div_t = {div_rem_q[15:0], div_lo_q[15]};
   wire div_ge = div_t >= {1'b0, div_den_q};
   wire [16:0] div_rem_n = div_ge ? 17'(div_t - {1'b0, div_den_q}) : div_t;
   wire [15:0] div_lo_n = {div_lo_q[14:0], div_ge};
   wire div_last = (div_st_q == alu_dsp_pkg::ST_DIV) && (div_cnt_q == 5'h01);
   wire [31:0] quo32 = cond_neg({16'h0, div_lo_n}, div_qneg_q);
   wire [31:0] rem32 = cond_neg({16'h0, div_rem_n[15:0]}, div_rneg_q);

   // ---------------------------------------------------------------
   // Status word next value
   // ---------------------------------------------------------------
   alu_dsp_pkg::flags_s st_d;
   always_comb begin
      st_d = status_q;
      if (apb_wr && hit_stat) begin
         st_d = alu_dsp_pkg::flags_s'(pwdata[4:0]);
      end
      // Hardware update wins over a software write in the same cycle
      if (issue && (is_arith || is_logic || is_shift)) begin
         st_d.z = alu_z;
         st_d.n = alu_n;
      end
      if (issue && (is_arith || is_shift)) begin
         st_d.c = alu_c;
      end
      if (issue && is_arith) begin
         st_d.ov = alu_ov;
         st_d.dc = alu_dc;
      end
      if (div_last) begin
         st_d.z = quo32[15:0] == 16'h0;
         st_d.n = quo32[15];
         st_d.ov = div_ovf_q;
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= apb_access & ~pready_q;
         prdata_q <= (apb_access & ~pready_q & ~pwrite) ? rd_data : 32'h0;
         pslverr_q <= apb_access & ~pready_q & ~hit_any;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTL_RESET;
         status_q <= `STATUS_RESET;
      end else begin
         if (apb_wr && hit_ctrl) begin
            ctrl_q <= pwdata[`CTL_W-1:0];
         end
         status_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // Accumulators
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_a_q <= 40'h0;
         acc_b_q <= 40'h0;
      end else if (issue && is_dsp && !op.acc_sel) begin
         acc_a_q <= acc_new;
      end else if (issue && is_dsp && op.acc_sel) begin
         acc_b_q <= acc_new;
      end
   end

   // ---------------------------------------------------------------
   // Divider sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_st_q <= alu_dsp_pkg::ST_IDLE;
         div_cnt_q <= 5'h0;
         div_rem_q <= 17'h0;
         div_lo_q <= 16'h0;
         div_den_q <= 16'h0;
         div_qneg_q <= 1'b0;
         div_rneg_q <= 1'b0;
         div_ovf_q <= 1'b0;
         div_dest_q <= 1'b0;
      end else begin
         case (div_st_q)
            alu_dsp_pkg::ST_IDLE: begin
               if (issue && is_div) begin
                  div_st_q <= alu_dsp_pkg::ST_DIV;
                  div_cnt_q <= `DIV_CYCLES;
                  div_rem_q <= {1'b0, dvd_mag[31:16]};
                  div_lo_q <= dvd_mag[15:0];
                  div_den_q <= den_mag;
                  div_qneg_q <= dvd_neg ^ den_neg;
                  div_rneg_q <= dvd_neg;
                  div_ovf_q <= div_ovf;
                  div_dest_q <= op.dest_mem;
               end
            end
            alu_dsp_pkg::ST_DIV: begin
               div_rem_q <= div_rem_n;
               div_lo_q <= div_lo_n;
               div_cnt_q <= 5'(div_cnt_q - 5'h01);
               if (div_last) begin
                  div_st_q <= alu_dsp_pkg::ST_IDLE;
               end
            end
            default: div_st_q <= alu_dsp_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Result port
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_q <= '0;
         div_done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         busy_q <= (div_st_q == alu_dsp_pkg::ST_DIV) ? !div_last : (issue && is_div);
         div_done_q <= div_last;
         res_q.valid <= 1'b0;
         if (div_last) begin
            res_q <= '{valid: 1'b1, dest_mem: div_dest_q,
                       lo: quo32[15:0], hi: rem32[15:0]};
         end else if (issue && (is_arith || is_logic || is_shift)) begin
            res_q <= '{valid: 1'b1, dest_mem: op.dest_mem,
                       lo: alu_out, hi: 16'h0};
         end else if (issue && is_mul) begin
            res_q <= '{valid: 1'b1, dest_mem: op.dest_mem,
                       lo: prod[15:0], hi: prod[31:16]};
         end else if (issue && is_dsp && op.wb && can_wb) begin
            res_q <= '{valid: 1'b1, dest_mem: 1'b1, lo: wb_word, hi: 16'h0};
         end
      end
   end

   // Squared difference forms its own 17-bit difference (sq_diff) ahead of the multiplier
   wire unused_sq = is_sq;

endmodule : cpu_alu_dsp_datapath

/* test/datapath_checker.sv */
module datapath_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic op_valid,
   input wire alu_dsp_pkg::op_s op,
   input wire alu_dsp_pkg::result_s res_q,
   input wire alu_dsp_pkg::flags_s status_q,
   input wire logic div_done_q,
   input wire logic busy_q
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic tk = op_valid && !busy_q && !op.byte_mode && !op.lit5;
   wire logic add_w = tk && op.code == alu_dsp_pkg::OP_ADD;
   wire logic sub_w = tk && op.code == alu_dsp_pkg::OP_SUB;
   wire logic mul_w = tk && op.code == alu_dsp_pkg::OP_MUL_UU;
   wire logic dvu_w = tk && op.code == alu_dsp_pkg::OP_DIV_U16 && op.y != 16'h0;
   wire logic div_w = tk && op.code inside {[alu_dsp_pkg::OP_DIV_S32:alu_dsp_pkg::OP_DIV_U16]};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence busy_run;
      busy_q [*8] ##1 busy_q [*8];
   endsequence
   a_div_span: assert property (div_w |=> busy_run ##1 div_done_q ##1 !div_done_q)
      else $error("divide span wrong");
   a_div_quot: assert property (dvu_w |-> ##17 res_q.lo == $past(op.x, 17) / $past(op.y, 17)
      && res_q.hi == $past(op.x, 17) % $past(op.y, 17)) else $error("quotient wrong");
   a_done_res: assert property (div_done_q |-> res_q.valid) else $error("done alone");
   a_add_sum: assert property (add_w |=> res_q.valid
      && res_q.lo == 16'($past(op.x) + $past(op.y))) else $error("sum wrong");
   a_sub_borrow: assert property (sub_w |=> status_q.c == ($past(op.x) >= $past(op.y)))
      else $error("borrow wrong");
   a_zero_neg: assert property ((add_w || sub_w) |=> status_q.z == (res_q.lo == 16'h0)
      && status_q.n == res_q.lo[15]) else $error("z or n wrong");
   a_mul_wide: assert property (mul_w |=> {res_q.hi, res_q.lo} == $past(op.x) * $past(op.y))
      else $error("product wrong");
   a_quiet_idle: assert property (!op_valid && !busy_q |=> !res_q.valid)
      else $error("result without op");
endmodule : datapath_checker

bind cpu_alu_dsp_datapath datapath_checker datapath_checker_inst (.pclk, .presetn, .op_valid,
   .op, .res_q, .status_q, .div_done_q, .busy_q);

/* test/op_feeder.sv */
module op_feeder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire alu_dsp_pkg::op_s nop,
   input wire logic busy_q,
   output logic op_valid,
   output alu_dsp_pkg::op_s op
);
   timeunit 1ns;
   timeprecision 1ps;
   // Holds one op until taken, then shows inverted operands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         {op_valid, op} <= '0;
      else if (go)
         {op_valid, op} <= {1'b1, nop};
      else if (op_valid && !busy_q)
         {op_valid, op} <= {1'b0, ~op};
   end
endmodule : op_feeder

/* test/testbench.sv */
`include "alu_dsp_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [4:0] c, st; logic [15:0] x, y, h, lo, hi;} row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_q;
   logic pready_q, pslverr_q, op_valid, div_done_q, busy_q;
   alu_dsp_pkg::op_s op, nop = '0;
   alu_dsp_pkg::result_s res_q;
   alu_dsp_pkg::flags_s status_q;
   int fails = 0, tests_run = 0;
   row_s rows [8] = '{
      '{5'h00,5'h1c,16'h7fff,16'h1,16'h0,16'h8000,16'h0},
      '{5'h01,5'h08,16'h0,16'h1,16'h0,16'hffff,16'h0},
      '{5'h02,5'h08,16'hf0f0,16'hff00,16'h0,16'hf000,16'h0},
      '{5'h05,5'h01,16'h8001,16'h1,16'h0,16'h2,16'h0},
      '{5'h09,5'h01,16'hffff,16'hffff,16'h0,16'h1,16'hfffe},
      '{5'h0a,5'h01,16'hffff,16'hffff,16'h0,16'h1,16'hffff},
      '{5'h10,5'h01,16'h64,16'h7,16'h0,16'he,16'h2},
      '{5'h0d,5'h09,16'h0,16'h4,16'hfffe,16'h8000,16'h0}};
   cpu_alu_dsp_datapath cpu_alu_dsp_datapath_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .op_valid, .op, .res_q, .status_q,
      .div_done_q, .busy_q);
   op_feeder op_feeder_inst (.pclk, .presetn, .go, .nop, .busy_q, .op_valid, .op);
   initial forever #2 pclk = ~pclk;
   task automatic chk(input logic [31:0] g, e);
      tests_run++;
      fails += (g !== e);
      if (g !== e) $display("mismatch at %0t: got %h want %h", $time, g, e);
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready_q !== 1'b1);
      chk(prdata_q, e);
      chk(pslverr_q, a > `OFS_SECOND_ACCUMULATOR_U);
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic run_op(input logic [4:0] c, input logic [15:0] x, y, h, input logic w,
                         input logic [4:0] m = 5'h00);
      int n = 0;
      @(posedge pclk);
      {go, nop} <= {1'b1, c, m, x, y, h};
      @(posedge pclk);
      go <= 1'b0;
      do @(negedge pclk); while (w && res_q.valid !== 1'b1 && ++n < 40);
      chk(n < 40, 32'h1);
      if (!w) repeat (2) @(negedge pclk);
   endtask : run_op
   task report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #20000 fails++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_CTRL, 32'h0, 32'h9);
      apb(1'b0, `OFS_FIRST_ACCUMULATOR_L, 32'h0, 32'h0);
      apb(1'b0, 8'h40, 32'h0, 32'h0);
      foreach (rows[i]) begin
         run_op(rows[i].c, rows[i].x, rows[i].y, rows[i].h, 1'b1);
         chk(res_q.lo, rows[i].lo);
         if (rows[i].c > 5'h05) chk(res_q.hi, rows[i].hi);
         chk(status_q, rows[i].st);
      end
      run_op(5'h00, 16'h12ff, 16'h1, 16'h0, 1'b1, 5'h18);
      chk({res_q.dest_mem, res_q.lo}, 32'h11200);
      chk(status_q, 32'h13);
      run_op(5'h09, 16'h3, 16'hffe5, 16'h0, 1'b1, 5'h04);
      chk({res_q.hi, res_q.lo}, 32'hf);
      apb(1'b1, `OFS_CTRL, 32'h0, 32'h0);
      run_op(5'h15, 16'h3, 16'h4, 16'h0, 1'b0);
      run_op(5'h14, 16'h2, 16'h5, 16'h0, 1'b0);
      apb(1'b0, `OFS_FIRST_ACCUMULATOR_L, 32'h0, 32'h16);
      run_op(5'h14, 16'h3, 16'h4, 16'h0, 1'b1, 5'h03);
      chk({res_q.dest_mem, res_q.lo}, 32'h10000);
      apb(1'b0, `OFS_SECOND_ACCUMULATOR_L, 32'h0, 32'hc);
      run_op(5'h1b, 16'h0, 16'h0, 16'h0, 1'b0);
      apb(1'b0, `OFS_FIRST_ACCUMULATOR_U, 32'h0, 32'hffff);
      run_op(5'h11, 16'h0, 16'h0, 16'h0, 1'b0);
      apb(1'b0, `OFS_FIRST_ACCUMULATOR_H, 32'h0, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_STATUS, 32'h0, 32'h0);
      apb(1'b0, `OFS_CTRL, 32'h0, 32'h9);
      report_and_stop();
   end
endmodule : testbench
